// ---- spio_ports.sv ----
// Purpose: Parallel I/O ports with peripheral sharing, reached over AXI4-Lite
// Assumes: Pads and peripherals are synchronous to clk_i; one write and one read in flight
// Notes: Pad outputs are registered, so a change reaches the pads one cycle after its cause
//
// Function
// - Driving peripheral disables port driver; pin readable
// - Enabled idle peripheral lets port drive pin
// - Direction one means input; zero drives latch
// - Reset makes every implemented pin an input
// - Latch register reads and writes the latch
// - Pin register reads pins, writes the latch
// - Unimplemented bits disabled and read as zero
// - Input-only shared pin acts as dedicated
// - Two muxes give peripheral pad ownership first
// - Analog-configured pins read zero in pin register
// - Digital inputs never routed to the converter
//
// Implementation choice: register access over AXI4-Lite.

`timescale 1ns/100ps

module spio_ports
    import spio_pkg::*;
(
    input wire logic clk_i,                                // 40 MHz system clock
    input wire logic rstn_i,                               // Synchronous reset, active low
    // AXI4-Lite write address channel
    input wire logic [AW-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    // AXI4-Lite write data channel
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response channel
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read address channel
    input wire logic [AW-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    // AXI4-Lite read data channel
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Pads and peripherals
    input wire logic [NBANK-1:0][BW-1:0] pad_in_i,        // Pad input levels
    input wire spio_periph_t [NBANK-1:0] periph_i,        // Peripheral claims per bank
    output logic [NBANK-1:0][BW-1:0] pad_out_o,           // Pad output data
    output logic [NBANK-1:0][BW-1:0] pad_oe_o,            // Pad output enable, high drives
    output logic [BW-1:0] analog_route_o                  // Pins of the analog bank fed to the converter
);

    // Port state
    logic [NBANK-1:0][BW-1:0] direction_register;         // One bit per pin, one is input
    logic [NBANK-1:0][BW-1:0] output_latch_register;      // Output latch per bank
    logic [BW-1:0] analog_pin_config;                     // One marks an analog input pin

    // Pad input synchronizer
    logic [NBANK-1:0][BW-1:0] pin_meta;                   // First stage, read only by pin_sync
    logic [NBANK-1:0][BW-1:0] pin_sync;                   // Second stage, safe to read

    // Write path holding registers
    logic aw_held;                                        // Write address captured
    logic w_held;                                         // Write data captured
    logic [AW-1:0] aw_addr;                               // Captured write address
    logic [BW-1:0] w_data;                                // Captured low half of write data
    logic [1:0] w_strb;                                   // Captured low byte strobes

    // Decode and selection wires
    spio_sel_t wr_sel;                                    // Register hit by the pending write
    spio_sel_t rd_sel;                                    // Register hit by the offered read
    logic wr_go;                                          // Pending write commits this cycle
    logic ar_take;                                        // Read address taken this cycle
    logic [BW-1:0] byte_mask;                             // Lanes selected by the strobes
    logic [NBANK-1:0] dir_we;                             // Direction write per bank
    logic [NBANK-1:0] lat_we;                             // Latch write per bank
    logic ana_we;                                         // Analog configuration write
    logic [NBANK-1:0][BW-1:0] dir_next;                   // Merged direction write value
    logic [NBANK-1:0][BW-1:0] lat_next;                   // Merged latch write value
    logic [NBANK-1:0][BW-1:0] pin_view;                   // Pin levels as software sees them
    logic [NBANK-1:0][BW-1:0] own;                        // Peripheral owns the pad
    logic [NBANK-1:0][BW-1:0] next_pad_out;               // Pad data before the output flop
    logic [NBANK-1:0][BW-1:0] next_pad_oe;                // Pad enable before the output flop
    logic [BW-1:0] ana_next;                              // Merged analog write value
    logic [BW-1:0] rd_val;                                // Selected read value

    // Address decode; the low two address bits are dropped, the strobes select the bytes
    assign wr_sel = spio_decode(aw_addr[AW-1:2]);
    assign rd_sel = spio_decode(s_axi_araddr_i[AW-1:2]);
    assign wr_go = aw_held && w_held && !s_axi_bvalid_o;
    assign ar_take = s_axi_arvalid_i && s_axi_arready_o;
    assign byte_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};
    assign ana_we = wr_go && (wr_sel.kind == KIND_ANA);
    assign ana_next = ((analog_pin_config & ~byte_mask) | (w_data & byte_mask)) & IMPL_MASK[ANA_BANK];

    // Per bank logic: write enables, merged values, pad muxes and the readable pin view
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        assign dir_we[b] = wr_go && (wr_sel.kind == KIND_DIR) && (wr_sel.bank == 3'(b));
        // A write to either the latch or the pin register lands in the latch
        assign lat_we[b] = wr_go && (wr_sel.kind == KIND_LAT || wr_sel.kind == KIND_PIN)
                           && (wr_sel.bank == 3'(b));
        // Unimplemented bits are forced to zero on every write
        assign dir_next[b] = ((direction_register[b] & ~byte_mask) | (w_data & byte_mask)) & IMPL_MASK[b];
        assign lat_next[b] = ((output_latch_register[b] & ~byte_mask) | (w_data & byte_mask)) & IMPL_MASK[b];
        // Ownership: an enabled peripheral that is driving wins; an idle one leaves the pin
        // to the port, which also covers input-only functions
        assign own[b] = periph_i[b].en & periph_i[b].drive;
        // Data and enable muxes, peripheral first
        assign next_pad_out[b] = ((own[b] & periph_i[b].data) | (~own[b] & output_latch_register[b]))
                                 & IMPL_MASK[b];
        // Port drives only where direction is zero
        assign next_pad_oe[b] = (own[b] | ~direction_register[b]) & IMPL_MASK[b];
        // Pins still read while a peripheral drives; analog pins read low
        if (b == int'(ANA_BANK)) begin : g_ana
            assign pin_view[b] = pin_sync[b] & IMPL_MASK[b] & ~analog_pin_config;
        end else begin : g_dig
            assign pin_view[b] = pin_sync[b] & IMPL_MASK[b];
        end
    end

    // Read mux; an unmapped index reads zero
    assign rd_val = (rd_sel.kind == KIND_DIR) ? direction_register[rd_sel.bank] :
                    (rd_sel.kind == KIND_PIN) ? pin_view[rd_sel.bank] :
                    (rd_sel.kind == KIND_LAT) ? output_latch_register[rd_sel.bank] :
                    (rd_sel.kind == KIND_ANA) ? analog_pin_config : 16'h0000;

    // Direction registers; reset makes every implemented pin an input
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < NBANK; b++) begin
            if (!rstn_i) begin
                direction_register[b] <= IMPL_MASK[b];
            end else if (dir_we[b]) begin
                direction_register[b] <= dir_next[b];
            end
        end
    end

    // Output latches
    always_ff @(posedge clk_i) begin
        for (int b = 0; b < NBANK; b++) begin
            if (!rstn_i) begin
                output_latch_register[b] <= LAT_RST;
            end else if (lat_we[b]) begin
                output_latch_register[b] <= lat_next[b];
            end
        end
    end

    // Analog configuration and converter routing; a digital pin is never routed
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            analog_pin_config <= ANA_RST;
            analog_route_o <= ANA_RST;
        end else begin
            if (ana_we) begin
                analog_pin_config <= ana_next;
            end
            // Routed from the stored setting, so an output pin still converts its driven level
            analog_route_o <= analog_pin_config;
        end
    end

    // Two-stage pad synchronizer; a pad change reaches software two cycles later
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pad_in_i;
            pin_sync <= pin_meta;
        end
    end

    // Registered pad drivers keep glitches from the muxes off the pins
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            pad_out_o <= '0;
            pad_oe_o <= '0;
        end else begin
            pad_out_o <= next_pad_out;
            pad_oe_o <= next_pad_oe;
        end
    end

    // Write address channel: take once, hold until the response is accepted
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_axi_awready_o <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr_i;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end else if (!aw_held && !s_axi_bvalid_o) begin
            s_axi_awready_o <= 1'b1;
        end
    end

    // Write data channel: only the low half carries register bits
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_axi_wready_o <= 1'b0;
            w_held <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            w_held <= 1'b1;
            w_data <= s_axi_wdata_i[BW-1:0];
            w_strb <= s_axi_wstrb_i[1:0];
        end else if (wr_go) begin
            w_held <= 1'b0;
        end else if (!w_held && !s_axi_bvalid_o) begin
            s_axi_wready_o <= 1'b1;
        end
    end

    // Write response: an unmapped address answers with a slave error
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= RESP_OKAY;
        end else if (wr_go) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= (wr_sel.kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // Read channel: data is captured at the address edge and held until taken
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= '0;
            s_axi_rresp_o <= RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o <= {16'h0000, rd_val};
            s_axi_rresp_o <= (rd_sel.kind == KIND_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end else if (!s_axi_rvalid_o) begin
            s_axi_arready_o <= 1'b1;
        end
    end

    // Checks

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);

    // Helper: read of the analog bank's pin register taken this cycle
    logic ana_pin_read;
    assign ana_pin_read = ar_take && (rd_sel.kind == KIND_PIN) && (rd_sel.bank == ANA_BANK);

    // Write sequence: both halves held, then the answer
    sequence wr_pending_s;
        aw_held && w_held && !s_axi_bvalid_o;
    endsequence

    sequence wr_answered_s;
        s_axi_bvalid_o && !aw_held && !w_held;
    endsequence

    reset_inputs_a: assert property (disable iff (1'b0) !rstn_i |=> direction_register == IMPL_MASK)
        else $error("direction not all inputs after reset");

    for (genvar b = 0; b < NBANK; b++) begin : g_chk
        // Guarded by reset so the release edge, which still resets the pads, is not judged
        periph_owns_a: assert property (
            rstn_i && own[b] != '0 |=> ((pad_oe_o[b] & $past(own[b])) == ($past(own[b]) & IMPL_MASK[b]))
                          && (((pad_out_o[b] ^ $past(periph_i[b].data)) & $past(own[b] & IMPL_MASK[b])) == '0))
            else $error("peripheral does not own driving pin");
        port_drives_a: assert property (
            ##1 (((pad_out_o[b] ^ $past(output_latch_register[b])) & $past(~own[b] & ~direction_register[b])
                  & IMPL_MASK[b]) == '0))
            else $error("port not driving from latch where peripheral idle");
        dir_input_a: assert property (
            ##1 ((pad_oe_o[b] & $past(~own[b] & direction_register[b])) == '0))
            else $error("input pin driven by port");
        unimpl_zero_a: assert property (
            ((direction_register[b] | output_latch_register[b] | pad_oe_o[b]) & ~IMPL_MASK[b]) == '0)
            else $error("unimplemented bit not zero");
        latch_write_a: assert property (
            lat_we[b] |=> output_latch_register[b] == $past(lat_next[b]))
            else $error("latch not updated by port write");
        // Starts only once reset is seen high; the release edge still clears both stages
        pin_sync_a: assert property (
            rstn_i |-> ##2 pin_sync[b] == $past(pad_in_i[b], 2))
            else $error("pin sample not two cycles late");
    end

    write_answer_a: assert property (wr_pending_s |=> wr_answered_s)
        else $error("write not answered next cycle");

    latch_readback_a: assert property (
        ar_take && rd_sel.kind == KIND_LAT |=> s_axi_rdata_o[BW-1:0] == $past(output_latch_register[rd_sel.bank]))
        else $error("latch read not the latch");

    analog_low_a: assert property (
        ana_pin_read |=> (s_axi_rdata_o[BW-1:0] & $past(analog_pin_config)) == '0)
        else $error("analog pin reads nonzero");

    analog_route_a: assert property (##1 (analog_route_o & ~$past(analog_pin_config)) == '0)
        else $error("digital pin routed to converter");

    // Read sequence: address taken, then the answer stands with the address channel closed
    sequence rd_taken_s;
        ar_take;
    endsequence

    sequence rd_answered_s;
        s_axi_rvalid_o && !s_axi_arready_o;
    endsequence

    // A read is answered on the next cycle; masters must still wait for rvalid, not count
    read_answer_a: assert property (rd_taken_s |=> rd_answered_s)
        else $error("read not answered next cycle");

    // A pin read never shows a one the synchronizer does not hold, nor an unimplemented bit
    pin_readback_a: assert property (
        ar_take && rd_sel.kind == KIND_PIN
        |=> (s_axi_rdata_o[BW-1:0] & ~$past(pin_sync[rd_sel.bank] & IMPL_MASK[rd_sel.bank])) == '0)
        else $error("pin read shows a level not held");

    // Direction reads back exactly what is stored
    dir_readback_a: assert property (
        ar_take && rd_sel.kind == KIND_DIR
        |=> s_axi_rdata_o[BW-1:0] == $past(direction_register[rd_sel.bank]))
        else $error("direction read not the register");

    // Analog configuration only ever holds pins of its own bank
    ana_impl_a: assert property ((analog_pin_config & ~IMPL_MASK[ANA_BANK]) == '0)
        else $error("analog configuration holds an unimplemented pin");

endmodule

// ---- spio_pkg.sv ----
// Purpose: Shared constants, types and address decode for the parallel I/O ports
// Assumes: Seven 16-bit banks; register indices are word indices on the bus
// Notes: Byte address of a register is four times its index

package spio_pkg;

    // Bank geometry
    localparam int NBANK = 7;                    // Banks A through G
    localparam int BW = 16;                      // Pins per bank
    localparam int AW = 12;                      // Byte address width on the bus
    localparam int IW = 10;                      // Register index width

    // Register indices, bank G in the top slot, bank A in the bottom slot
    localparam logic [NBANK-1:0][IW-1:0] DIR_IDX = {10'h2e4, 10'h2ee, 10'h2d8, 10'h2d2, 10'h2cc, 10'h2c6, 10'h2c0};
    localparam logic [NBANK-1:0][IW-1:0] PIN_IDX = {10'h2e6, 10'h2e0, 10'h2da, 10'h2d4, 10'h2ce, 10'h2c8, 10'h2c2};
    localparam logic [NBANK-1:0][IW-1:0] LAT_IDX = {10'h2e8, 10'h2e2, 10'h2dc, 10'h2d6, 10'h200, 10'h2cb, 10'h2c4};
    localparam logic [IW-1:0] ANA_IDX = 10'h2a8;  // Analog pin configuration

    // Implemented pins per bank; also the direction value after reset (all inputs)
    localparam logic [NBANK-1:0][BW-1:0] IMPL_MASK = {16'h03cf, 16'h01ff, 16'h03ff, 16'hffff,
                                                      16'he00a, 16'hffff, 16'hc600};
    localparam logic [BW-1:0] LAT_RST = 16'h0000;  // Output latch after reset
    localparam logic [BW-1:0] ANA_RST = 16'h0000;  // All pins digital after reset
    localparam logic [2:0] ANA_BANK = 3'h1;        // Bank whose pins feed the converter

    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Kind of register hit by an address
    typedef enum logic [2:0] {KIND_NONE, KIND_DIR, KIND_PIN, KIND_LAT, KIND_ANA} spio_kind_t;

    // Decoded register selection
    typedef struct packed {
        spio_kind_t kind;
        logic [2:0] bank;
    } spio_sel_t;

    // Signals one on-chip peripheral offers to the pads of a bank
    typedef struct packed {
        logic [BW-1:0] en;     // Peripheral enabled
        logic [BW-1:0] drive;  // Peripheral actively driving the pin
        logic [BW-1:0] data;   // Peripheral output level
    } spio_periph_t;

    // Map a register index onto kind and bank
    function automatic spio_sel_t spio_decode(input logic [IW-1:0] idx);
        spio_sel_t sel;
        sel.kind = KIND_NONE;
        sel.bank = 3'h0;
        if (idx == ANA_IDX) begin
            sel.kind = KIND_ANA;
            sel.bank = ANA_BANK;
        end
        for (int b = 0; b < NBANK; b++) begin
            if (idx == DIR_IDX[b]) begin
                sel.kind = KIND_DIR;
                sel.bank = 3'(b);
            end
            if (idx == PIN_IDX[b]) begin
                sel.kind = KIND_PIN;
                sel.bank = 3'(b);
            end
            if (idx == LAT_IDX[b]) begin
                sel.kind = KIND_LAT;
                sel.bank = 3'(b);
            end
        end
        return sel;
    endfunction

endpackage

// ---- spio_pad_model.sv ----
// Purpose: Pad wiring model; outside sources meet the port and peripheral drivers
// Assumes: The outside source is weak, so a driven pad always shows the driven level
// Notes: No pulls; an undriven pad follows the outside level only

`timescale 1ns/100ps

module spio_pad_model
    import spio_pkg::*;
(
    input wire logic [NBANK-1:0][BW-1:0] pad_out_i,   // Level driven by the block
    input wire logic [NBANK-1:0][BW-1:0] pad_oe_i,    // High where the block drives
    input wire logic [NBANK-1:0][BW-1:0] ext_level_i, // Level forced from outside
    output logic [NBANK-1:0][BW-1:0] pad_in_o         // Resolved pad level
);
    // Driven bits win; any other bit shows the outside level, never a stale value
    assign pad_in_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_level_i);
endmodule

// ---- spio_ports_tb.sv ----
// Purpose: Self-checking bench for the parallel I/O ports over AXI4-Lite
// Assumes: Master holds each channel until taken; pads resolved by the pad model
// Notes: Three edges pass after a write so pads and the synchronizer settle

`timescale 1ns/100ps

module spio_ports_tb
    import spio_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic [AW-1:0] awaddr = '0;
    logic [AW-1:0] araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    spio_periph_t [NBANK-1:0] periph = '0;                  // Peripheral claims
    logic [NBANK-1:0][BW-1:0] ext_level = {NBANK{16'hffff}}; // Outside levels
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rd_val;
    logic [NBANK-1:0][BW-1:0] pad_in, pad_out, pad_oe;
    logic [BW-1:0] analog_route;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    always #12.5 clk_i = ~clk_i;

    spio_ports uut (
        .clk_i(clk_i), .rstn_i(rstn_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
        .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
        .pad_in_i(pad_in), .periph_i(periph), .pad_out_o(pad_out), .pad_oe_o(pad_oe),
        .analog_route_o(analog_route)
    );

    spio_pad_model pads (
        .pad_out_i(pad_out), .pad_oe_i(pad_oe), .ext_level_i(ext_level), .pad_in_o(pad_in)
    );

    // Byte address of a register index
    function automatic logic [AW-1:0] adr(input logic [IW-1:0] i);
        return {i, 2'b00};
    endfunction

    // Compare and count
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            errors++;
        end
    endtask

    // Write: address and data offered together, each dropped once taken
    task automatic wr(input logic [AW-1:0] a, input logic [BW-1:0] d);
        @(posedge clk_i);
        awaddr <= a;
        wdata <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Ends when bvalid is seen; the bench timeout catches a missing answer
        forever begin
            @(posedge clk_i);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
        // Gap before a readback, also lets pads and synchronizer catch up
        repeat (3) @(posedge clk_i);
    endtask

    // Read: answer taken at the edge where rvalid is seen with rready high
    task automatic rd(input logic [AW-1:0] a);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        // Ends when rvalid is seen; the bench timeout catches a missing answer
        forever begin
            @(posedge clk_i);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rd_val = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // Read a register; upper half must read zero as well
    task automatic rchk(input logic [AW-1:0] a, input logic [BW-1:0] exp, input string nm);
        rd(a);
        chk(nm, {16'h0000, exp}, rd_val);
    endtask

    // Single exit point of the run
    task automatic final_report();
        $display("errors=%0d checked=%0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard, far above the fewer than two hundred cycles the run needs
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            final_report();
        end
    end

    initial begin
        ext_level[1] <= 16'h3cff;
        repeat (12) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        // Reset state of every bank, unimplemented bits zero
        chk("oe_reset", 32'h0, {31'h0, |pad_oe});
        for (int b = 0; b < NBANK; b++) begin
            rchk(adr(DIR_IDX[b]), IMPL_MASK[b], "dir_reset");
            rchk(adr(LAT_IDX[b]), LAT_RST, "lat_reset");
            rchk(adr(PIN_IDX[b]), ext_level[b] & IMPL_MASK[b], "pin_reset");
        end
        // Latch store, low byte of bank B as outputs
        wr(adr(LAT_IDX[1]), 16'ha5a5);
        chk("bresp_ok", RESP_OKAY, resp);
        rchk(adr(LAT_IDX[1]), 16'ha5a5, "lat_b");
        wr(adr(DIR_IDX[1]), 16'hff00);
        chk("oe_b", 32'h00ff, pad_oe[1]);
        chk("out_b", 32'h00a5, pad_out[1] & 16'h00ff);
        rchk(adr(PIN_IDX[1]), 16'h3ca5, "pin_b");
        wr(adr(PIN_IDX[1]), 16'h1234);
        rchk(adr(LAT_IDX[1]), 16'h1234, "pinwr_lat_b");
        // Unimplemented bits, including the odd latch index of bank C
        wr(adr(LAT_IDX[0]), 16'hffff);
        rchk(adr(LAT_IDX[0]), 16'hc600, "lat_a");
        wr(adr(LAT_IDX[2]), 16'hffff);
        rchk(adr(LAT_IDX[2]), 16'he00a, "lat_c");
        wr(adr(DIR_IDX[2]), 16'h0000);
        chk("oe_c", 32'he00a, pad_oe[2]);
        // Peripheral owns and drives bit 2 (low) and bit 15 (high)
        @(posedge clk_i);
        periph[1] <= '{en: 16'h8004, drive: 16'h8004, data: 16'h8000};
        repeat (3) @(posedge clk_i);
        chk("own_oe", 32'h80ff, pad_oe[1]);
        chk("own_out", 32'h8030, pad_out[1] & pad_oe[1]);
        rchk(adr(PIN_IDX[1]), 16'hbc30, "own_pin");
        // Enabled but idle peripheral, input-only function on bit 12
        periph[1] <= '{en: 16'h1004, drive: 16'h0000, data: 16'h0000};
        repeat (3) @(posedge clk_i);
        chk("idle_oe", 32'h00ff, pad_oe[1]);
        chk("idle_out", 32'h0034, pad_out[1] & pad_oe[1]);
        rchk(adr(PIN_IDX[1]), 16'h3c34, "idle_pin");
        periph[1] <= '0;
        // Analog pins: inputs first, then configure
        wr(adr(DIR_IDX[1]), 16'hffff);
        wr(adr(ANA_IDX), 16'h0f0f);
        chk("route", 32'h0f0f, analog_route);
        rchk(adr(PIN_IDX[1]), 16'h30f0, "ana_pin");
        wr(adr(ANA_IDX), 16'h0000);
        chk("route_off", 32'h0, analog_route);
        // Unmapped place refused both ways
        wr(12'h004, 16'hffff);
        chk("bad_bresp", RESP_SLVERR, resp);
        rd(12'h004);
        chk("bad_rresp", RESP_SLVERR, resp);
        chk("bad_rdata", 32'h0, rd_val);
        final_report();
    end
endmodule
